//--- verilog/lvreg_pkg.sv
// How it works
// R1: The monitor register low nibble holds the 4-bit code of the higher LED voltage, 0 below 3.2V, 0.1V per step.
// R2: Manual mode lets software request conversions while automatic conversions keep running.
// R3: Automatic mode starts a conversion every time a flash pulse begins.
// R4: With the shutdown bit set no conversion is performed; cleared (default) the converter runs.
// R5: The read-only done flag reads 0 during and after reset and goes to 1 when a result is valid.
// R6: A read of the monitor register clears the done flag, except in the cycle a conversion finishes.
// R7: A conversion starts a programmable delay after the done flag falls, 250us per code step up to 8ms.
// R8: The delay applies to manual and automatic conversions alike.
// R9: The no-delay bit makes the conversion start at once after the done flag falls.
// R10: Supply monitor enable in bit 0 (default off), threshold in bits 2:1, default 2.9V.
// R11: Flash-time supply watch enable in bit 3 (default off), threshold in bits 5:4, same encoding.
// R12: Two source bits choose the privacy channels, channel one on and channel two off by default.
// R13: Privacy-terminate chooses whether privacy comes back after a flash pulse, default stays off.
// R14: A 3-bit privacy level sets 10% to 80% of minimum torch current, default 10%.
// R15: Unused bits read as zero and ignore writes.
package lvreg_pkg;
  // ****************************************
  // Register addresses
  // ****************************************
  localparam logic [7:0] LVREG_ADDR_MON   = 8'h00;
  localparam logic [7:0] LVREG_ADDR_DELAY = 8'h01;
  localparam logic [7:0] LVREG_ADDR_VIN   = 8'h02;
  localparam logic [7:0] LVREG_ADDR_PRIV  = 8'h03;

  // ****************************************
  // Field layout and reset values
  // ****************************************
  localparam int          LVREG_MON_MANUAL_BIT = 4;
  localparam int          LVREG_MON_SHDN_BIT   = 5;
  localparam int          LVREG_MON_DONE_BIT   = 6;
  localparam int          LVREG_DLY_NODLY_BIT  = 5;
  localparam logic [7:0]  LVREG_DELAY_MASK     = 8'h3F;
  localparam logic [7:0]  LVREG_VIN_MASK       = 8'h3F;
  localparam logic [7:0]  LVREG_PRIV_MASK      = 8'h3F;
  localparam logic [7:0]  LVREG_DELAY_RST      = 8'h00;
  localparam logic [7:0]  LVREG_VIN_RST        = 8'h00;
  localparam logic [7:0]  LVREG_PRIV_RST       = 8'h18;

  // ****************************************
  // Timing
  // ****************************************
  localparam int          LVREG_CLK_HZ         = 50_000_000;
  localparam int          LVREG_STEP_US        = 250;
  localparam int          LVREG_STEP_CYC       = LVREG_STEP_US * (LVREG_CLK_HZ / 1_000_000);
  localparam int          LVREG_CONV_CYC       = 16;

  typedef enum logic [1:0] {LVREG_IDLE, LVREG_WAIT, LVREG_CONV} lvreg_state_e;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lvreg_req_s;
endpackage

//--- verilog/lvreg_top.sv
`timescale 1ns/1ps
module lvreg_top #(
  parameter int STEP_CYC = lvreg_pkg::LVREG_STEP_CYC, // Cycles per delay step
  parameter int CONV_CYC = lvreg_pkg::LVREG_CONV_CYC  // Cycles a conversion takes
) (
  input  wire logic                 core_clk,      // Device clock
  input  wire logic                 rst_n,         // Synchronous reset, active low
  input  wire lvreg_pkg::lvreg_req_s req,          // Register access, one-cycle strobes
  output logic [7:0]                rdata_ff,      // Read data, valid cycle after rd
  input  wire logic                 flash_start,   // Flash pulse begins, one cycle
  input  wire logic                 flash_end,     // Flash pulse ends, one cycle
  input  wire logic                 manual_req,    // Software conversion request pulse
  input  wire logic [3:0]           adc_code,      // Analog result, higher channel voltage
  output logic                      adc_sample_ff, // Converter sampling window
  output logic                      vin_en_ff,     // Supply monitor enable
  output logic [1:0]                vin_th_ff,     // Supply monitor threshold code
  output logic                      flash_supply_watch_ff, // Flash-time supply watch enable
  output logic [1:0]                flash_th_ff,   // Flash-time threshold code
  output logic                      channel_one_source_ff, // Channel one lights in privacy
  output logic                      channel_two_source_ff, // Channel two lights in privacy
  output logic [2:0]                privacy_level_ff,      // Privacy current code
  output logic                      privacy_on_ff  // Privacy indicator active
);
  import lvreg_pkg::*;

  // ****************************************
  // Register storage
  // ****************************************
  logic [3:0]   result_ff;
  logic         manual_ff;
  logic         shdn_ff;
  logic         done_ff;
  logic [7:0]   delay_ff;
  logic [7:0]   vin_ff;
  logic [7:0]   priv_ff;
  lvreg_state_e state_ff;
  // 19 bits: the longest wait is 32 steps of 12500 cycles, beyond 18 bits
  logic [18:0]  cnt_ff;
  logic         pend_ff;

  function automatic logic hit(input lvreg_req_s r, input logic [7:0] a);
    hit = (r.addr == a);
  endfunction

  wire mon_rd   = req.rd && hit(req, LVREG_ADDR_MON);
  wire conv_end = (state_ff == LVREG_CONV) && (cnt_ff == 19'(CONV_CYC - 1));
  // Delay total: (code+1) steps, or none when the no-delay bit is set
  wire [18:0] wait_cyc = delay_ff[LVREG_DLY_NODLY_BIT] ? 19'h0_0000 :   // R9
                         19'((int'(delay_ff[4:0]) + 1) * STEP_CYC - 1); // R7
  wire trig = !shdn_ff && (flash_start || (manual_ff && manual_req)); // R2 R3 R4 R8

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      manual_ff <= 1'b0;
      shdn_ff   <= 1'b0;
    end else if (req.wr && hit(req, LVREG_ADDR_MON)) begin
      manual_ff <= req.wdata[LVREG_MON_MANUAL_BIT];
      shdn_ff   <= req.wdata[LVREG_MON_SHDN_BIT]; // R4
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      delay_ff <= LVREG_DELAY_RST;
      vin_ff   <= LVREG_VIN_RST;
      priv_ff  <= LVREG_PRIV_RST;
    end else if (req.wr) begin
      if (hit(req, LVREG_ADDR_DELAY)) delay_ff <= req.wdata & LVREG_DELAY_MASK; // R15
      if (hit(req, LVREG_ADDR_VIN))   vin_ff   <= req.wdata & LVREG_VIN_MASK;   // R10 R11
      if (hit(req, LVREG_ADDR_PRIV))  priv_ff  <= req.wdata & LVREG_PRIV_MASK;  // R12 R13 R14
    end
  end

  // ****************************************
  // Conversion sequencer
  // ****************************************
  // A trigger during a running conversion is held pending rather than dropped
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_ff <= LVREG_IDLE;
      cnt_ff   <= 19'h0_0000;
      pend_ff  <= 1'b0;
    end else if (shdn_ff) begin
      state_ff <= LVREG_IDLE; // R4
      cnt_ff   <= 19'h0_0000;
      pend_ff  <= 1'b0;
    end else begin
      case (state_ff)
        LVREG_IDLE: begin
          if (trig || pend_ff) begin
            state_ff <= LVREG_WAIT; // R7
            cnt_ff   <= 19'h0_0000;
            pend_ff  <= 1'b0;
          end
        end
        LVREG_WAIT: begin
          if (trig) pend_ff <= 1'b1;
          if (cnt_ff >= wait_cyc) begin
            state_ff <= LVREG_CONV;
            cnt_ff   <= 19'h0_0000;
          end else begin
            cnt_ff <= cnt_ff + 19'h0_0001;
          end
        end
        LVREG_CONV: begin
          if (trig) pend_ff <= 1'b1;
          if (conv_end) begin
            state_ff <= LVREG_IDLE;
            cnt_ff   <= 19'h0_0000;
          end else begin
            cnt_ff <= cnt_ff + 19'h0_0001;
          end
        end
        default: begin
          state_ff <= LVREG_IDLE;
          cnt_ff   <= 19'h0_0000;
        end
      endcase
    end
  end

  // Done flag: a finishing conversion wins over a same-cycle read clear
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      done_ff   <= 1'b0;
      result_ff <= 4'h0;
    end else if (conv_end && !shdn_ff) begin
      done_ff   <= 1'b1;     // R5
      result_ff <= adc_code; // R1
    end else if (mon_rd || trig) begin
      done_ff <= 1'b0;       // R6
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) adc_sample_ff <= 1'b0;
    else        adc_sample_ff <= (state_ff == LVREG_CONV) && !conv_end && !shdn_ff;
  end

  // ****************************************
  // Read path and decoded outputs
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rdata_ff <= 8'h00;
    end else if (req.rd) begin
      case (req.addr)
        LVREG_ADDR_MON:   rdata_ff <= {1'b0, done_ff, shdn_ff, manual_ff, result_ff}; // R1 R15
        LVREG_ADDR_DELAY: rdata_ff <= delay_ff;
        LVREG_ADDR_VIN:   rdata_ff <= vin_ff;
        LVREG_ADDR_PRIV:  rdata_ff <= priv_ff;
        default:          rdata_ff <= 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      vin_en_ff             <= 1'b0;
      vin_th_ff             <= 2'h0;
      flash_supply_watch_ff <= 1'b0;
      flash_th_ff           <= 2'h0;
      channel_one_source_ff <= 1'b1;
      channel_two_source_ff <= 1'b0;
      privacy_level_ff      <= 3'h0;
    end else begin
      vin_en_ff             <= vin_ff[0];   // R10
      vin_th_ff             <= vin_ff[2:1]; // R10
      flash_supply_watch_ff <= vin_ff[3];   // R11
      flash_th_ff           <= vin_ff[5:4]; // R11
      channel_one_source_ff <= priv_ff[4];  // R12
      channel_two_source_ff <= priv_ff[5];  // R12
      privacy_level_ff      <= priv_ff[2:0]; // R14
    end
  end

  // Privacy goes dark during the flash and returns only if terminate is clear
  always_ff @(posedge core_clk) begin
    if (!rst_n)           privacy_on_ff <= 1'b1;
    else if (flash_start) privacy_on_ff <= 1'b0;
    else if (flash_end)   privacy_on_ff <= !priv_ff[3]; // R13
  end
endmodule

//--- sim/lvreg_checker_assertions.sv
`timescale 1ns/1ps
module lvreg_checker #(
  parameter int CONV_CYC = 4 // Conversion cycles
) (
  input wire logic                  core_clk, // Clock
  input wire logic                  rst_n, // Reset
  input wire lvreg_pkg::lvreg_req_s req, // Access
  input wire logic [7:0]            rdata_ff, // Read data
  input wire logic                  adc_sample_ff, // Converting
  input wire logic                  vin_en_ff, // Monitor on
  input wire logic [1:0]            vin_th_ff, // Threshold
  input wire logic                  flash_supply_watch_ff, // Watch on
  input wire logic [1:0]            flash_th_ff, // Threshold
  input wire logic                  channel_one_source_ff, // Source
  input wire logic                  channel_two_source_ff, // Source
  input wire logic [2:0]            privacy_level_ff // Level
);
  import lvreg_pkg::*;
  // ****
  // Shadow state and checks
  // ****
  logic       shdn_ff;
  logic [7:0] cnt_ff;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      shdn_ff <= 1'b0;
      cnt_ff  <= 8'h00;
    end else begin
      if (req.wr && req.addr == LVREG_ADDR_MON) shdn_ff <= req.wdata[5];
      cnt_ff <= adc_sample_ff ? cnt_ff + 8'h01 : 8'h00;
    end
  end
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Idle converter for three cycles keeps a late done set out of the window
  sequence s_quiet_rd;
    req.rd && req.addr == LVREG_ADDR_MON
      && !(adc_sample_ff || $past(adc_sample_ff) || $past(adc_sample_ff, 2));
  endsequence
  unmapped_rd_a: assert property (req.rd && req.addr > 8'h03 |=> rdata_ff == 8'h00)
    else $error("unmapped read not zero");
  unused_rd_a: assert property (req.rd |=>
    !rdata_ff[7] && ($past(req.addr) == 8'h00 || !rdata_ff[6])) else $error("unused bit set");
  done_clear_a: assert property (s_quiet_rd ##1 s_quiet_rd |=> !rdata_ff[6])
    else $error("done not cleared by read");
  shdn_block_a: assert property (shdn_ff && $past(shdn_ff) && $past(shdn_ff, 2)
    |-> !adc_sample_ff) else $error("conversion while shut down");
  // Sampling window is one cycle shorter than the conversion state
  conv_max_a: assert property (cnt_ff <= 8'(CONV_CYC - 1)) else $error("conversion too long");
  conv_len_a: assert property ($fell(adc_sample_ff)
    && !(shdn_ff || $past(shdn_ff) || $past(shdn_ff, 2)) |-> cnt_ff == 8'(CONV_CYC - 1))
    else $error("conversion length wrong");
  priv_follow_a: assert property (req.wr && req.addr == LVREG_ADDR_PRIV |-> ##2
    {channel_two_source_ff, channel_one_source_ff, privacy_level_ff}
      == {$past(req.wdata[5:4], 2), $past(req.wdata[2:0], 2)}) else $error("privacy field");
  vin_follow_a: assert property (req.wr && req.addr == LVREG_ADDR_VIN |-> ##2
    {flash_th_ff, flash_supply_watch_ff, vin_th_ff, vin_en_ff} == $past(req.wdata[5:0], 2))
    else $error("supply field");
endmodule
bind lvreg_top lvreg_checker #(.CONV_CYC(CONV_CYC)) lvreg_checker_inst (.core_clk, .rst_n,
  .req, .rdata_ff, .adc_sample_ff, .vin_en_ff, .vin_th_ff, .flash_supply_watch_ff,
  .flash_th_ff, .channel_one_source_ff, .channel_two_source_ff, .privacy_level_ff);

//--- sim/tb_lvreg_top.sv
`timescale 1ns/1ps
module tb_lvreg_top;
  import lvreg_pkg::*;
  logic       core_clk = 1'b0, rst_n = 1'b0, flash_start = 1'b0;
  logic       flash_end = 1'b0, manual_req = 1'b0;
  logic       adc_sample_ff, vin_en_ff, flash_supply_watch_ff, privacy_on_ff;
  logic       channel_one_source_ff, channel_two_source_ff;
  logic [1:0] vin_th_ff, flash_th_ff;
  logic [2:0] privacy_level_ff;
  logic [3:0] adc_code = 4'h0, c;
  logic [7:0] rdata_ff, v, a, d;
  logic [7:0] dl [4] = '{8'h20, 8'h00, 8'h03, 8'h1F};
  lvreg_req_s req = '0;
  int         fail_count = 0, num_checks = 0, seed = 81879, n, w;
  always #10 core_clk = ~core_clk;
  lvreg_top #(.STEP_CYC(4), .CONV_CYC(4)) lvreg_top_inst (.core_clk, .rst_n, .req, .rdata_ff,
    .flash_start, .flash_end, .manual_req, .adc_code, .adc_sample_ff, .vin_en_ff, .vin_th_ff,
    .flash_supply_watch_ff, .flash_th_ff, .channel_one_source_ff, .channel_two_source_ff,
    .privacy_level_ff, .privacy_on_ff);
  // ****
  // Bench tasks
  // ****
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic logic [7:0] exp_rb(input logic [7:0] ea, ed);
    return (ea >= 8'h01 && ea <= 8'h03) ? (ed & 8'h3F) : 8'h00;
  endfunction
  task automatic wr(input logic [7:0] wa, wd);
    req <= '{1'b1, 1'b0, wa, wd};
    @(posedge core_clk);
    req <= '0;
    @(posedge core_clk);
  endtask
  task automatic rdr(input logic [7:0] ra, output logic [7:0] rv);
    req <= '{1'b0, 1'b1, ra, 8'h00};
    @(posedge core_clk);
    req <= '0;
    @(posedge core_clk);
    rv = rdata_ff;
  endtask
  // Bounded wait: a conversion that never starts shows as n == 400
  task automatic trig(input logic man, output int tn);
    if (man) manual_req <= 1'b1;
    else flash_start <= 1'b1;
    @(posedge core_clk);
    manual_req <= 1'b0;
    flash_start <= 1'b0;
    tn = 0;
    while (adc_sample_ff !== 1'b1 && tn < 400) begin
      @(negedge core_clk);
      tn++;
    end
    repeat (8) @(posedge core_clk);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #200_000;
    fail_count++;
    close_out();
  end
  initial begin
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    chk("ch1_src", {7'h00, channel_one_source_ff}, 8'h01);
    for (int i = 0; i < 6; i++) begin
      rdr(8'(i), v);
      chk("reset_val", v, i == 3 ? 8'h18 : 8'h00);
    end
    for (int i = 0; i < 24; i++) begin
      a = i < 3 ? 8'(i + 1) : 8'(1 + {$random(seed)} % 5);
      d = i < 3 ? 8'hFF : 8'($random(seed));
      wr(a, d);
      rdr(a, v);
      chk("cfg_rb", v, exp_rb(a, d));
    end
    wr(8'h00, 8'h10);
    foreach (dl[k]) begin
      c = 4'($random(seed));
      adc_code <= c;
      wr(8'h01, dl[k]);
      w = dl[k][5] ? 1 : (dl[k][4:0] + 1) * 4;
      trig(k[0], n);
      chk("conv_wait", 8'(n >= w && n <= w + 2), 8'h01);
      req <= '{1'b0, 1'b1, 8'h00, 8'h00};
      @(posedge core_clk);
      @(negedge core_clk);
      chk("mon_done", rdata_ff, {4'h5, c});
      @(posedge core_clk);
      req <= '0;
      @(negedge core_clk);
      chk("mon_clr", rdata_ff, {4'h1, c});
      @(posedge core_clk);
    end
    wr(8'h00, 8'h00);
    trig(1'b1, n);
    chk("no_manual", 8'(n), 8'(400));
    for (int t = 0; t < 2; t++) begin
      wr(8'h03, {4'h1, t[0], 3'h0});
      trig(1'b0, n);
      flash_end <= 1'b1;
      @(posedge core_clk);
      flash_end <= 1'b0;
      repeat (3) @(posedge core_clk);
      chk("privacy_on", {7'h00, privacy_on_ff}, {7'h00, !t[0]});
    end
    wr(8'h00, 8'h20);
    trig(1'b0, n);
    chk("shdn_idle", 8'(n), 8'(400));
    rdr(8'h00, v);
    chk("shdn_mon", v & 8'hBF, {4'h2, c});
    close_out();
  end
endmodule
